// ---- shared/adcp_pkg.sv ----
// package for the sampling and power-down control block of the eight-channel converter
// assumes a single 10 MHz clock and an APB slave holding the software view
package adcp_pkg;

   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   // longest conversion time, in its own unit
   localparam int CONVERSION_TIME_MAX_NS = 8000;
   localparam int CONV_MAX_CYCLES = CONVERSION_TIME_MAX_NS / CLK_PERIOD_NS;
   // internal oscillator: one tick every OSC_DIV clocks
   localparam logic [2:0] OSC_DIV = 3'h2;
   localparam logic [2:0] TICKS_PER_CH = 3'h4;
   localparam int NUM_CH = 8;
   localparam int CODE_W = 14;
   localparam int WORD_W = 16;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_RESULT0 = 8'h10;
   localparam logic [7:0] REG_RESULT_LAST = 8'h2c;
   localparam int CTRL_START_EN_BIT = 0;
   localparam int CTRL_SOFT_RESET_BIT = 1;
   localparam logic CTRL_START_EN_RST = 1'b1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_MODE_LSB = 1;
   localparam int STAT_NEED_RESET_BIT = 4;
   localparam int STAT_HELD_A_BIT = 5;
   localparam int STAT_HELD_B_BIT = 6;
   localparam int STAT_FRAME_BIT = 7;
   localparam int STAT_INDEX_LSB = 8;
   localparam int STAT_CLOSED_BIT = 11;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      MODE_ACTIVE = 3'b001,
      MODE_STANDBY = 3'b010,
      MODE_SHUTDOWN = 3'b100
   } adcp_mode_t;

   typedef struct packed
   {
      logic power_down_n;
      logic range_sel;
      logic sample_start_group_a;
      logic sample_start_group_b;
      logic cs_n;
      logic rd_n;
      logic conv_reset;
   } adcp_pins_t;

   // idle pin levels used as synchroniser reset value
   localparam adcp_pins_t PINS_IDLE = 7'h66;

   typedef logic [NUM_CH-1:0][WORD_W-1:0] adcp_words_t;

endpackage : adcp_pkg

// ---- core/adcp_conv_engine.sv ----
// conversion sequencer: walks all eight channels on the oscillator tick
// assumes start and abort are one-cycle pulses on mclk, adc_code settles within one tick
`timescale 1ns/10ps
module adcp_conv_engine
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic osc_tick,
   input wire logic start,
   input wire logic abort,
   input wire logic [13:0] adc_code,
   output logic [2:0] adc_ch_sel,
   output logic done,
   output adcp_pkg::adcp_words_t conv_data
);

   typedef enum logic [1:0]
   {
      ENG_IDLE = 2'b01,
      ENG_CONV = 2'b10
   } adcp_eng_state_t;

   typedef struct packed
   {
      adcp_eng_state_t state;
      logic [2:0] ch;
      logic [2:0] tick_cnt;
      logic done;
      adcp_pkg::adcp_words_t data;
   } adcp_eng_t;

   adcp_eng_t st_reg;
   adcp_eng_t st_next;

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.done = 1'b0;
      unique case (st_reg.state)
         ENG_IDLE:
         begin
            if (start && !abort)
            begin
               st_next.state = ENG_CONV;
               st_next.ch = 3'h0;
               st_next.tick_cnt = 3'h0;
            end
         end
         ENG_CONV:
         begin
            if (abort)
            begin
               st_next.state = ENG_IDLE;
            end
            else if (osc_tick)
            begin
               if (st_reg.tick_cnt == adcp_pkg::TICKS_PER_CH - 3'h1)
               begin
                  // every channel is converted, used or not
                  st_next.data[st_reg.ch] = {adc_code, 2'h0};
                  st_next.tick_cnt = 3'h0;
                  if (st_reg.ch == 3'h7)
                  begin
                     st_next.done = 1'b1;
                     st_next.state = ENG_IDLE;
                  end
                  else
                  begin
                     st_next.ch = st_reg.ch + 3'h1;
                  end
               end
               else
               begin
                  st_next.tick_cnt = st_reg.tick_cnt + 3'h1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_reg <= '{state: ENG_IDLE, ch: 3'h0, tick_cnt: 3'h0, done: 1'b0, data: '0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign adc_ch_sel = st_reg.ch;
   assign done = st_reg.done;
   assign conv_data = st_reg.data;

   a_word_pad: assert property (@(posedge mclk) disable iff (!resetn)
      done |-> (conv_data[7][1:0] == 2'h0 && conv_data[0][1:0] == 2'h0))
      else $error("result word lacks two trailing zeros");

endmodule : adcp_conv_engine

// ---- core/adcp_ctrl.sv ----
// power-down, sample-start, busy and parallel readout control of an eight-channel converter
// assumes pins arrive asynchronously, APB master on mclk, analog code supplied on adc_code
//
// Operation
// - power_down_n low with range high puts the device in standby
// - power_down_n low with range low puts the device in shutdown
// - power-down entry acts on pin levels at once, with no clock
// - standby powers down only the channel front ends
// - shutdown powers down everything, reference and regulator too
// - common start rise holds all channels and starts conversion
// - busy rises at conversion start, stays high within the maximum time
// - results update and busy falls at the same edge, marking them valid
// - first strobe fall after busy gives channel 1, then channels in order
// - every channel is always converted and sent
// - first-channel flag high on first fall, low from next fall on
// - raising both strobes ends frame; bus and flag float until next conversion
// - separate group starts each hold their group; convert after both
// - reads during busy give previous sample, after busy the current
// - result word is 14-bit code followed by two zero bits
`timescale 1ns/10ps
module adcp_ctrl
(
   input wire logic mclk,
   input wire logic resetn,
   input wire adcp_pkg::adcp_pins_t pins,
   input wire logic [13:0] adc_code,
   output logic [2:0] adc_ch_sel,
   output logic busy,
   output logic [15:0] parallel_result_bus,
   output logic parallel_result_bus_oe,
   output logic first_channel_flag,
   output logic first_channel_flag_oe,
   output logic frontend_pd,
   output logic refreg_pd,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   typedef struct packed
   {
      adcp_pkg::adcp_pins_t s1;
      adcp_pkg::adcp_pins_t s2;
      adcp_pkg::adcp_pins_t prev;
      adcp_pkg::adcp_mode_t mode;
      logic need_reset;
      logic held_a;
      logic held_b;
      logic busy;
      logic start_pulse;
      logic abort_pulse;
      logic start_en;
      logic frame_active;
      logic frame_closed;
      logic [2:0] rd_index;
      logic bus_oe;
      logic flag;
      logic [15:0] bus_data;
      adcp_pkg::adcp_words_t results;
      logic [2:0] osc_cnt;
      logic osc_tick;
      logic [31:0] prdata;
      logic [7:0] busy_len;
   } adcp_ctrl_t;

   adcp_ctrl_t st_reg;
   adcp_ctrl_t st_next;
   logic eng_done;
   adcp_pkg::adcp_words_t eng_data;

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   function automatic logic reg_hit(input logic [7:0] addr);
      reg_hit = (addr == adcp_pkg::REG_CTRL) || (addr == adcp_pkg::REG_STATUS) ||
         (addr >= adcp_pkg::REG_RESULT0 && addr <= adcp_pkg::REG_RESULT_LAST && addr[1:0] == 2'h0);
   endfunction : reg_hit

   function automatic logic [31:0] reg_read(input logic [7:0] addr, input adcp_ctrl_t s);
      logic [7:0] off;
      off = addr - adcp_pkg::REG_RESULT0;
      reg_read = 32'h0;
      if (!reg_hit(addr))
         reg_read = 32'h0;
      else if (addr == adcp_pkg::REG_CTRL)
         reg_read[adcp_pkg::CTRL_START_EN_BIT] = s.start_en;
      else if (addr == adcp_pkg::REG_STATUS)
      begin
         reg_read[adcp_pkg::STAT_BUSY_BIT] = s.busy;
         reg_read[adcp_pkg::STAT_MODE_LSB +: 3] = s.mode;
         reg_read[adcp_pkg::STAT_NEED_RESET_BIT] = s.need_reset;
         reg_read[adcp_pkg::STAT_HELD_A_BIT] = s.held_a;
         reg_read[adcp_pkg::STAT_HELD_B_BIT] = s.held_b;
         reg_read[adcp_pkg::STAT_FRAME_BIT] = s.frame_active;
         reg_read[adcp_pkg::STAT_INDEX_LSB +: 3] = s.rd_index;
         reg_read[adcp_pkg::STAT_CLOSED_BIT] = s.frame_closed;
      end
      else
         reg_read[15:0] = s.results[off[4:2]];
   endfunction : reg_read

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic pd;
      logic a_rise;
      logic b_rise;
      logic rd_fall;
      logic frame_end;
      logic soft_reset;
      logic reset_evt;
      logic accept;
      pd = 1'b0;
      a_rise = 1'b0;
      b_rise = 1'b0;
      rd_fall = 1'b0;
      frame_end = 1'b0;
      soft_reset = 1'b0;
      reset_evt = 1'b0;
      accept = 1'b0;
      st_next = st_reg;
      // only s2 and prev feed logic; s1 is the metastability stage
      st_next.s1 = pins;
      st_next.s2 = st_reg.s1;
      st_next.prev = st_reg.s2;
      st_next.start_pulse = 1'b0;
      st_next.abort_pulse = 1'b0;

      pd = !st_reg.s2.power_down_n;
      a_rise = st_reg.s2.sample_start_group_a && !st_reg.prev.sample_start_group_a;
      b_rise = st_reg.s2.sample_start_group_b && !st_reg.prev.sample_start_group_b;
      rd_fall = !st_reg.s2.rd_n && st_reg.prev.rd_n && !st_reg.s2.cs_n;
      frame_end = st_reg.s2.cs_n && st_reg.s2.rd_n && !(st_reg.prev.cs_n && st_reg.prev.rd_n);
      soft_reset = psel && penable && pwrite && paddr == adcp_pkg::REG_CTRL &&
         pwdata[adcp_pkg::CTRL_SOFT_RESET_BIT];
      reset_evt = (st_reg.s2.conv_reset && !st_reg.prev.conv_reset) || soft_reset;

      // internal oscillator divider
      st_next.osc_tick = (st_reg.osc_cnt == adcp_pkg::OSC_DIV - 3'h1);
      st_next.osc_cnt = st_next.osc_tick ? 3'h0 : st_reg.osc_cnt + 3'h1;

      // power mode follows the synchronised pins
      if (pd)
         st_next.mode = st_reg.s2.range_sel ? adcp_pkg::MODE_STANDBY : adcp_pkg::MODE_SHUTDOWN;
      else
         st_next.mode = adcp_pkg::MODE_ACTIVE;

      // ---- reset pin / soft reset: clears pending work ----
      if (reset_evt)
      begin
         st_next.need_reset = 1'b0;
         st_next.held_a = 1'b0;
         st_next.held_b = 1'b0;
         st_next.frame_active = 1'b0;
         st_next.rd_index = 3'h0;
      end
      // shutdown entry beats a simultaneous reset
      if (pd && !st_reg.s2.range_sel)
         st_next.need_reset = 1'b1;

      // abort a running conversion on power-down or reset; results keep the last sample
      if ((pd || reset_evt) && st_reg.busy)
      begin
         st_next.busy = 1'b0;
         st_next.abort_pulse = 1'b1;
      end
      if (pd)
      begin
         st_next.held_a = 1'b0;
         st_next.held_b = 1'b0;
      end

      // ---- sample start ----
      accept = !pd && !reset_evt && st_reg.mode == adcp_pkg::MODE_ACTIVE && !st_reg.busy &&
         !st_reg.need_reset && st_reg.start_en;
      if (accept && a_rise)
         st_next.held_a = 1'b1;
      if (accept && b_rise)
         st_next.held_b = 1'b1;
      if (accept && (st_reg.held_a || a_rise) && (st_reg.held_b || b_rise))
      begin
         // joined starts rise together and fire here at once
         st_next.held_a = 1'b0;
         st_next.held_b = 1'b0;
         st_next.start_pulse = 1'b1;
         st_next.busy = 1'b1;
         st_next.frame_closed = 1'b0;
         st_next.frame_active = 1'b0;
      end

      // results and busy fall at the same edge, so the fall marks valid words
      if (eng_done && st_reg.busy)
      begin
         st_next.results = eng_data;
         st_next.busy = 1'b0;
      end

      // ---- parallel readout ----
      if (rd_fall && !st_reg.frame_closed)
      begin
         if (!st_reg.frame_active)
         begin
            st_next.bus_data = st_reg.results[0];
            st_next.flag = 1'b1;
            st_next.rd_index = 3'h1;
            st_next.frame_active = 1'b1;
         end
         else
         begin
            st_next.bus_data = st_reg.results[st_reg.rd_index];
            st_next.flag = 1'b0;
            st_next.rd_index = st_reg.rd_index + 3'h1;
         end
      end
      if (frame_end && st_reg.frame_active)
      begin
         st_next.frame_active = 1'b0;
         st_next.frame_closed = 1'b1;
         st_next.rd_index = 3'h0;
         st_next.flag = 1'b0;
      end
      st_next.bus_oe = !st_reg.s2.cs_n && !st_next.frame_closed;

      // ---- APB ----
      if (psel && !penable && !pwrite)
         st_next.prdata = reg_read(paddr, st_reg);
      if (psel && penable && pwrite && paddr == adcp_pkg::REG_CTRL)
         st_next.start_en = pwdata[adcp_pkg::CTRL_START_EN_BIT];

      // assertion helper: length of the current busy pulse
      st_next.busy_len = st_reg.busy ? st_reg.busy_len + 8'h1 : 8'h0;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_reg <= '{s1: adcp_pkg::PINS_IDLE, s2: adcp_pkg::PINS_IDLE, prev: adcp_pkg::PINS_IDLE,
            mode: adcp_pkg::MODE_ACTIVE, start_en: adcp_pkg::CTRL_START_EN_RST, default: '0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   adcp_conv_engine u_engine
   (
      .mclk(mclk),
      .resetn(resetn),
      .osc_tick(st_reg.osc_tick),
      .start(st_reg.start_pulse),
      .abort(st_reg.abort_pulse),
      .adc_code(adc_code),
      .adc_ch_sel(adc_ch_sel),
      .done(eng_done),
      .conv_data(eng_data)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // power gating straight from the pins so entry needs no clock
   assign frontend_pd = !pins.power_down_n;
   assign refreg_pd = !pins.power_down_n && !pins.range_sel;
   assign busy = st_reg.busy;
   assign parallel_result_bus = st_reg.bus_data;
   assign parallel_result_bus_oe = st_reg.bus_oe;
   assign first_channel_flag = st_reg.flag;
   assign first_channel_flag_oe = st_reg.bus_oe;
   assign prdata = st_reg.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !reg_hit(paddr);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_standby_entry: assert property (@(posedge mclk) disable iff (!resetn)
      (!st_reg.s2.power_down_n && st_reg.s2.range_sel) |=> st_reg.mode == adcp_pkg::MODE_STANDBY)
      else $error("standby not entered");
   a_shutdown_entry: assert property (@(posedge mclk) disable iff (!resetn)
      (!st_reg.s2.power_down_n && !st_reg.s2.range_sel) |=> st_reg.mode == adcp_pkg::MODE_SHUTDOWN
      && st_reg.need_reset)
      else $error("shutdown not entered");
   a_standby_power: assert property (@(posedge mclk) disable iff (!resetn)
      (!pins.power_down_n && pins.range_sel) |-> (frontend_pd && !refreg_pd))
      else $error("standby gating wrong");
   a_start_busy: assert property (@(posedge mclk) disable iff (!resetn)
      st_reg.start_pulse |-> busy ##1 (u_engine.st_reg.state != 2'b01))
      else $error("start did not begin conversion");
   a_busy_bound: assert property (@(posedge mclk) disable iff (!resetn)
      st_reg.busy_len <= 8'(adcp_pkg::CONV_MAX_CYCLES))
      else $error("busy longer than the maximum conversion time");
   a_results_fall: assert property (@(posedge mclk) disable iff (!resetn)
      $fell(busy) && !$past(st_reg.abort_pulse) && $past(eng_done) |-> st_reg.results == $past(eng_data))
      else $error("results not updated at busy fall");
   a_results_hold: assert property (@(posedge mclk) disable iff (!resetn)
      (busy && $past(busy)) |-> $stable(st_reg.results))
      else $error("results changed during conversion");
   a_first_word: assert property (@(posedge mclk) disable iff (!resetn)
      (!st_reg.s2.rd_n && st_reg.prev.rd_n && !st_reg.s2.cs_n && !st_reg.frame_active && !st_reg.frame_closed)
      |=> (parallel_result_bus == $past(st_reg.results[0]) && first_channel_flag))
      else $error("first strobe did not give channel 1");
   a_flag_drop: assert property (@(posedge mclk) disable iff (!resetn)
      (!st_reg.s2.rd_n && st_reg.prev.rd_n && !st_reg.s2.cs_n && st_reg.frame_active)
      |=> !first_channel_flag)
      else $error("first-channel flag not cleared");
   a_frame_float: assert property (@(posedge mclk) disable iff (!resetn)
      st_reg.frame_closed |=> (!parallel_result_bus_oe || st_reg.start_pulse))
      else $error("bus driven after frame end");
   a_half_hold: assert property (@(posedge mclk) disable iff (!resetn)
      (st_reg.held_a && !st_reg.held_b && st_reg.s2.sample_start_group_b == st_reg.prev.sample_start_group_b)
      |=> !st_reg.start_pulse)
      else $error("conversion began with one group held");
   a_busy_ignore: assert property (@(posedge mclk) disable iff (!resetn)
      (busy || st_reg.mode != adcp_pkg::MODE_ACTIVE) |=> !$rose(st_reg.held_a))
      else $error("start taken while busy or powered down");

endmodule : adcp_ctrl

// ---- testbench/adcp_host_model.sv ----
// host side model: drives the converter pins, keeps the host's exit delays
// assumes mclk runs and pins are sampled by the block through synchronisers
`timescale 1ns/10ps
module adcp_host_model
#(
   parameter int STANDBY_EXIT_CYCLES = 1000,
   parameter int SHUTDOWN_EXIT_CYCLES = 130000
)
(
   input wire logic mclk,
   output adcp_pkg::adcp_pins_t pins
);
   logic was_shutdown = 1'b0;
   initial pins = adcp_pkg::PINS_IDLE;
   task automatic hold(input int n);
      repeat (n) @(posedge mclk);
   endtask : hold
   // joined groups rise on one edge
   task automatic start(input logic a, input logic b);
      @(posedge mclk);
      pins.sample_start_group_a <= a;
      pins.sample_start_group_b <= b;
      hold(5);
      pins.sample_start_group_a <= 1'b0;
      pins.sample_start_group_b <= 1'b0;
      hold(5);
   endtask : start
   task automatic strobes(input logic cs, input logic rd);
      @(posedge mclk);
      pins.cs_n <= cs;
      pins.rd_n <= rd;
      hold(5);
   endtask : strobes
   // starts are withheld until the settle time has run out
   task automatic power(input logic pdn, input logic range);
      @(posedge mclk);
      pins.power_down_n <= pdn;
      pins.range_sel <= range;
      if (!pdn)
         was_shutdown = !range;
      else
         hold(was_shutdown ? SHUTDOWN_EXIT_CYCLES : STANDBY_EXIT_CYCLES);
   endtask : power
   task automatic reset_pulse();
      @(posedge mclk);
      pins.conv_reset <= 1'b1;
      hold(5);
      pins.conv_reset <= 1'b0;
      hold(5);
   endtask : reset_pulse
endmodule : adcp_host_model

// ---- testbench/adcp_tb.sv ----
// self-checking bench for the sampling, power-down and readout control block
// assumes the host model above and a code source of {salt, channel}
`timescale 1ns/10ps
module tb;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   adcp_pkg::adcp_pins_t pins;
   logic [10:0] salt = 11'h155;
   logic [2:0] adc_ch_sel;
   logic busy, oe, flag, flag_oe, frontend_pd, refreg_pd, pready, pslverr;
   logic [15:0] bus;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic err;
   int fails = 0;
   int checks_done = 0;
   always #50 mclk = ~mclk;
   // shutdown settle shortened to keep the run short
   adcp_host_model #(.STANDBY_EXIT_CYCLES(1000), .SHUTDOWN_EXIT_CYCLES(300)) adcp_host_model_inst
      (.mclk(mclk), .pins(pins));
   adcp_ctrl adcp_ctrl_inst
   (
      .mclk(mclk), .resetn(resetn), .pins(pins), .adc_code({salt, adc_ch_sel}), .adc_ch_sel(adc_ch_sel),
      .busy(busy), .parallel_result_bus(bus), .parallel_result_bus_oe(oe), .first_channel_flag(flag),
      .first_channel_flag_oe(flag_oe), .frontend_pd(frontend_pd), .refreg_pd(refreg_pd), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr)
   );
   task automatic print_verdict();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         chk(32'h1, 32'h0);
         print_verdict();
      end
   endtask : apb
   task automatic wait_busy(input logic lvl, input int lim);
      int n;
      for (n = 0; n < lim && busy !== lvl; n++)
         step(1);
      chk({31'h0, busy}, {31'h0, lvl});
      if (busy !== lvl)
         print_verdict();
   endtask : wait_busy
   task automatic check_results();
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, adcp_pkg::REG_RESULT0 + 8'(4 * i), 32'h0);
         chk(rd, {16'h0, salt, 3'(i), 2'b00});
      end
   endtask : check_results
   task automatic read_frame();
      adcp_host_model_inst.strobes(1'b0, 1'b1);
      for (int i = 0; i < 8; i++)
      begin
         adcp_host_model_inst.strobes(1'b0, 1'b0);
         #1;
         chk({oe, bus}, {1'b1, salt, 3'(i), 2'b00});
         chk({flag_oe, flag}, {1'b1, i == 0});
         adcp_host_model_inst.strobes(1'b0, 1'b1);
      end
      adcp_host_model_inst.strobes(1'b1, 1'b1);
      #1;
      chk({oe, flag_oe}, 2'b00);
   endtask : read_frame
   task automatic joined_conversion();
      adcp_host_model_inst.start(1'b1, 1'b1);
      wait_busy(1'b1, 10);
      wait_busy(1'b0, 80);
      check_results();
      read_frame();
   endtask : joined_conversion
   task automatic split_and_busy();
      logic [10:0] old_salt;
      old_salt = salt;
      salt <= 11'h2aa;
      adcp_host_model_inst.start(1'b1, 1'b0);
      step(10);
      chk({31'h0, busy}, 32'h0);
      adcp_host_model_inst.start(1'b0, 1'b1);
      wait_busy(1'b1, 10);
      apb(1'b0, adcp_pkg::REG_RESULT0, 32'h0);
      chk(rd, {16'h0, old_salt, 5'h0});
      adcp_host_model_inst.start(1'b1, 1'b1);
      wait_busy(1'b0, 80);
      step(10);
      chk({31'h0, busy}, 32'h0);
      check_results();
      read_frame();
   endtask : split_and_busy
   task automatic start_disabled();
      apb(1'b1, adcp_pkg::REG_CTRL, 32'h0);
      adcp_host_model_inst.start(1'b1, 1'b1);
      chk({31'h0, busy}, 32'h0);
      apb(1'b1, adcp_pkg::REG_CTRL, 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1);
      // soft reset mid-conversion: busy drops, stored words keep the last full sample
      salt <= 11'h0f0;
      adcp_host_model_inst.start(1'b1, 1'b1);
      wait_busy(1'b1, 10);
      apb(1'b1, adcp_pkg::REG_CTRL, 32'h3);
      step(2);
      chk({31'h0, busy}, 32'h0);
      apb(1'b0, adcp_pkg::REG_RESULT0, 32'h0);
      chk(rd, {16'h0, 11'h2aa, 5'h0});
   endtask : start_disabled
   task automatic power_modes();
      adcp_host_model_inst.power(1'b0, 1'b1);
      #1;
      chk({frontend_pd, refreg_pd}, 2'b10);
      adcp_host_model_inst.start(1'b1, 1'b1);
      chk({31'h0, busy}, 32'h0);
      apb(1'b0, adcp_pkg::REG_STATUS, 32'h0);
      chk(rd[3:1], 3'b010);
      adcp_host_model_inst.power(1'b1, 1'b1);
      adcp_host_model_inst.power(1'b0, 1'b0);
      #1;
      chk({frontend_pd, refreg_pd}, 2'b11);
      step(5);
      apb(1'b0, adcp_pkg::REG_STATUS, 32'h0);
      chk(rd[3:1], 3'b100);
      adcp_host_model_inst.power(1'b1, 1'b1);
      adcp_host_model_inst.start(1'b1, 1'b1);
      chk({31'h0, busy}, 32'h0);
      adcp_host_model_inst.reset_pulse();
      salt <= 11'h3c3;
      joined_conversion();
   endtask : power_modes
   initial
   begin
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      step(2);
      chk({busy, oe, flag_oe}, 3'b000);
      apb(1'b0, adcp_pkg::REG_CTRL, 32'h0);
      chk(rd, 32'h1);
      joined_conversion();
      split_and_busy();
      start_disabled();
      power_modes();
      print_verdict();
   end
   initial
   begin
      #5ms;
      chk(32'h1, 32'h0);
      print_verdict();
   end
endmodule : tb
